// ---- rtl/radio_spi_master.sv ----
// SFR-side SPI master for the embedded radio: registers, two-byte queues, control lines.
// Assumes SFR strobes are one-cycle pulses on clock_in; the shifter runs on link_clock_in.
// How it works
// R01: Interrupt mask has four bits, resets to all ones; one disables a source.
// R02: Interrupt rises when any active source has its mask bit clear.
// R03: Status bit 3 reads one while the receive queue is full.
// R04: Status bit 2 reads one while the receive queue holds a byte.
// R05: Status bit 1 reads one while the transmit queue is empty.
// R06: Status bit 0 reads one while the transmit queue has a free slot.
// R07: Status is read-only, resets to 0x03, and flags follow their causes.
// R08: Data writes push the transmit queue, reads pop the receive queue; two deep.
// R09: Free-slot flag tells software it may refill the transmit queue.
// R10: Byte-available flag is set only when a received byte can be read.
// R11: Software leaves the reserved configuration register at its reset value.
// R12: Control bit 2 enables the 16 MHz radio clock.
// R13: Control bit 1 drives the active-low slave select.
// R14: Control bit 0 drives chip enable; bits 7 to 3 are reserved.
// R15: Software clears slave select before writing each command byte.
// R16: With the first byte, the byte read back is the radio status.
// R17: Bytes shift most significant bit first; data bytes go low byte first.
// R18: Each queued byte is shifted out while selected, one byte captured back.
`timescale 1ns/1ps
`default_nettype none
module radio_spi_master (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic link_clock_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  output logic irq_out,
  output logic radio_sck_out,
  output logic radio_mosi_out,
  input wire logic radio_miso_in,
  output logic radio_csn_out,
  output logic radio_ce_out,
  output logic radio_clock_enable_line_out
);
  link_handshake_if hs ();

  logic [6:0] reserved_cfg;
  logic [3:0] irq_mask;
  logic [2:0] control;
  logic [3:0] fifo_flags;
  logic [7:0] tx_mem [2];
  logic tx_wr_ptr, tx_rd_ptr;
  logic [1:0] tx_count;
  logic [7:0] rx_mem [2];
  logic rx_wr_ptr, rx_rd_ptr;
  logic [1:0] rx_count;
  logic tx_push, tx_pop, rx_push, rx_pop;
  logic data_wr, data_rd;
  logic ack_s1, ack_s2, ack_s3, ack_seen;
  logic ack_event;
  logic req;
  logic [7:0] tx_hold;
  radio_spi_pkg::launch_state_e launch_state;
  logic launch;

  assign data_wr = sfr_wr_in && sfr_addr_in == radio_spi_pkg::FIFO_DATA_ADDR;
  assign data_rd = sfr_rd_in && sfr_addr_in == radio_spi_pkg::FIFO_DATA_ADDR;

  // Writable registers
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      reserved_cfg <= radio_spi_pkg::RESERVED_CFG_RESET;
    end else if (sfr_wr_in && sfr_addr_in == radio_spi_pkg::RESERVED_CFG_ADDR) begin
      reserved_cfg <= sfr_wdata_in[6:0];
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      irq_mask <= radio_spi_pkg::IRQ_MASK_RESET; // R01
    end else if (sfr_wr_in && sfr_addr_in == radio_spi_pkg::IRQ_MASK_ADDR) begin
      irq_mask <= sfr_wdata_in[3:0]; // R01
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      control <= radio_spi_pkg::CONTROL_RESET;
    end else if (sfr_wr_in && sfr_addr_in == radio_spi_pkg::CONTROL_ADDR) begin
      control <= sfr_wdata_in[2:0]; // R14
    end
  end

  assign radio_clock_enable_line_out = control[radio_spi_pkg::CTRL_CLOCK_EN]; // R12
  assign radio_csn_out = control[radio_spi_pkg::CTRL_SELECT_N]; // R13
  assign radio_ce_out = control[radio_spi_pkg::CTRL_CHIP_EN]; // R14

  // Transmit queue: full writes are dropped
  assign tx_push = data_wr && tx_count != radio_spi_pkg::QUEUE_DEPTH; // R08
  assign tx_pop = launch;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      tx_wr_ptr <= 1'b0;
      tx_rd_ptr <= 1'b0;
    end else begin
      if (tx_push) begin
        tx_mem[tx_wr_ptr] <= sfr_wdata_in;
        tx_wr_ptr <= ~tx_wr_ptr;
      end
      if (tx_pop) begin
        tx_rd_ptr <= ~tx_rd_ptr;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      tx_count <= 2'h0;
    end else if (tx_push && !tx_pop) begin
      tx_count <= tx_count + 2'd1;
    end else if (tx_pop && !tx_push) begin
      tx_count <= tx_count - 2'd1;
    end
  end

  // Receive queue: empty reads return zero and pop nothing
  assign rx_push = ack_event;
  assign rx_pop = data_rd && rx_count != 2'h0; // R08

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rx_wr_ptr <= 1'b0;
      rx_rd_ptr <= 1'b0;
    end else begin
      if (rx_push) begin
        rx_mem[rx_wr_ptr] <= hs.rx_byte; // R16
        rx_wr_ptr <= ~rx_wr_ptr;
      end
      if (rx_pop) begin
        rx_rd_ptr <= ~rx_rd_ptr;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rx_count <= 2'h0;
    end else if (rx_push && !rx_pop) begin
      rx_count <= rx_count + 2'd1;
    end else if (rx_pop && !rx_push) begin
      rx_count <= rx_count - 2'd1;
    end
  end

  // Completion toggle from the link domain
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      ack_s3 <= 1'b0;
      ack_seen <= 1'b0;
    end else begin
      ack_s1 <= hs.ack_toggle;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
      if (ack_event) begin
        ack_seen <= ack_s3;
      end
    end
  end
  assign ack_event = ack_s2 == ack_s3 && ack_s3 != ack_seen;

  // One byte in flight; launch only while selected and with receive room
  assign launch = launch_state == radio_spi_pkg::LAUNCH_IDLE && tx_count != 2'h0
    && !control[radio_spi_pkg::CTRL_SELECT_N] && rx_count != radio_spi_pkg::QUEUE_DEPTH; // R18

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      launch_state <= radio_spi_pkg::LAUNCH_IDLE;
      req <= 1'b0;
      tx_hold <= 8'h00;
    end else begin
      case (launch_state)
        radio_spi_pkg::LAUNCH_IDLE: begin
          if (launch) begin
            tx_hold <= tx_mem[tx_rd_ptr]; // R18
            req <= ~req;
            launch_state <= radio_spi_pkg::LAUNCH_BUSY;
          end
        end
        radio_spi_pkg::LAUNCH_BUSY: begin
          if (ack_event) begin
            launch_state <= radio_spi_pkg::LAUNCH_IDLE;
          end
        end
        default: launch_state <= radio_spi_pkg::LAUNCH_IDLE;
      endcase
    end
  end
  assign hs.req_toggle = req;
  assign hs.tx_byte = tx_hold;

  // Status flags follow the queue levels directly
  assign fifo_flags[radio_spi_pkg::FLAG_RX_FULL] = rx_count == radio_spi_pkg::QUEUE_DEPTH; // R03
  assign fifo_flags[radio_spi_pkg::FLAG_RX_AVAIL] = rx_count != 2'h0; // R04
  assign fifo_flags[radio_spi_pkg::FLAG_TX_EMPTY] = tx_count == 2'h0; // R05
  assign fifo_flags[radio_spi_pkg::FLAG_TX_SLOT] = tx_count != radio_spi_pkg::QUEUE_DEPTH; // R06 R09

  // Each source gated by its own mask bit
  logic [3:0] irq_source;
  for (genvar s = 0; s < 4; s++) begin : gen_irq_source
    assign irq_source[s] = fifo_flags[s] && !irq_mask[s]; // R02
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |irq_source; // R02
    end
  end

  // Read data, registered one cycle after the strobe
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sfr_rdata_out <= radio_spi_pkg::FIFO_DATA_RESET;
    end else if (sfr_rd_in) begin
      case (sfr_addr_in)
        radio_spi_pkg::RESERVED_CFG_ADDR: sfr_rdata_out <= {1'b0, reserved_cfg};
        radio_spi_pkg::IRQ_MASK_ADDR: sfr_rdata_out <= {4'h0, irq_mask};
        radio_spi_pkg::FIFO_FLAGS_ADDR: sfr_rdata_out <= {4'h0, fifo_flags}; // R07
        radio_spi_pkg::FIFO_DATA_ADDR: sfr_rdata_out <= rx_pop ? rx_mem[rx_rd_ptr] : 8'h00; // R10
        radio_spi_pkg::CONTROL_ADDR: sfr_rdata_out <= {5'h00, control};
        default: sfr_rdata_out <= 8'h00;
      endcase
    end
  end

  spi_link_shifter shifter (
    .link_clock_in(link_clock_in),
    .rst_in(rst_in),
    .miso_in(radio_miso_in),
    .sck_out(radio_sck_out),
    .mosi_out(radio_mosi_out),
    .hs(hs.link_side)
  );

  default clocking main_clk @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  mask_reset_a: assert property ($past(rst_in) |-> irq_mask == 4'hF) // R01
    else $error("mask not all ones after reset");
  irq_gate_a: assert property (##1 irq_out == |($past(fifo_flags) & ~$past(irq_mask))) // R02
    else $error("interrupt does not follow unmasked flags");
  masked_quiet_a: assert property (irq_mask == 4'hF |=> !irq_out) // R02
    else $error("interrupt with all sources masked");
  rx_full_flag_a: assert property (rx_push && !rx_pop && rx_count == 2'h1 |=> fifo_flags[3]) // R03
    else $error("receive full flag missing");
  rx_avail_flag_a: assert property (rx_push |=> fifo_flags[2]) // R04
    else $error("byte available flag missing after capture");
  tx_empty_flag_a: assert property (tx_push |=> !fifo_flags[1]) // R05
    else $error("transmit empty flag still set after push");
  tx_slot_flag_a: assert property (tx_pop && !tx_push |=> fifo_flags[0]) // R06
    else $error("free slot flag missing after pop");
  flags_reset_a: assert property ($past(rst_in) |-> fifo_flags == 4'h3) // R07
    else $error("status not 0x03 after reset");
  push_count_a: assert property (tx_push && !tx_pop |=> tx_count == $past(tx_count) + 2'd1) // R08
    else $error("data write did not queue a byte");
  pop_count_a: assert property (rx_pop && !rx_push |=> rx_count == $past(rx_count) - 2'd1) // R08
    else $error("data read did not pop a byte");
  refill_room_a: assert property (data_wr && fifo_flags[0] |-> tx_push) // R09
    else $error("write refused while slot flagged free");
  empty_read_a: assert property (data_rd && rx_count == 2'h0 |=> sfr_rdata_out == 8'h00) // R10
    else $error("read from empty queue returned data");
  control_bits_a: assert property (sfr_wr_in && sfr_addr_in == 8'hE8 |=> // R12
    {radio_clock_enable_line_out, radio_csn_out, radio_ce_out} == $past(sfr_wdata_in[2:0]))
    else $error("control lines do not follow write");
  launch_select_a: assert property (launch |-> !radio_csn_out ##1 launch_state == radio_spi_pkg::LAUNCH_BUSY) // R13
    else $error("byte launched without slave select");
  byte_round_a: assert property (launch |=> !launch ##1 !launch) // R18
    else $error("second launch while byte in flight");

  // Registers change only when written, read data only when read
  mask_hold_a: assert property ( // R01
    !(sfr_wr_in && sfr_addr_in == radio_spi_pkg::IRQ_MASK_ADDR) |=> $stable(irq_mask))
    else $error("mask moved unwritten");
  control_hold_a: assert property ( // R14
    !(sfr_wr_in && sfr_addr_in == radio_spi_pkg::CONTROL_ADDR) |=> $stable(control))
    else $error("control moved unwritten");
  rdata_hold_a: assert property (!sfr_rd_in |=> $stable(sfr_rdata_out)) // R07
    else $error("read data moved unread");
  flags_read_a: assert property (sfr_rd_in && sfr_addr_in == radio_spi_pkg::FIFO_FLAGS_ADDR |=> // R07
    sfr_rdata_out[7:4] == 4'h0 && sfr_rdata_out[3] == ($past(rx_count) == 2'h2)
    && sfr_rdata_out[1] == ($past(tx_count) == 2'h0))
    else $error("status read wrong");

  // Queue contents and levels
  tx_store_a: assert property (tx_push |=> tx_mem[$past(tx_wr_ptr)] == $past(sfr_wdata_in)) // R08
    else $error("written byte not queued");
  rx_store_a: assert property (rx_push |=> rx_mem[$past(rx_wr_ptr)] == $past(hs.rx_byte)) // R16
    else $error("received byte not queued");
  data_pop_a: assert property (rx_pop |=> sfr_rdata_out == $past(rx_mem[rx_rd_ptr])) // R08
    else $error("wrong byte read");
  tx_bound_a: assert property (tx_count <= radio_spi_pkg::QUEUE_DEPTH) // R08
    else $error("transmit level too high");
  rx_bound_a: assert property (rx_count <= radio_spi_pkg::QUEUE_DEPTH) // R08
    else $error("receive level too high");
  full_drop_a: assert property (data_wr && !tx_pop && tx_count == radio_spi_pkg::QUEUE_DEPTH |=> // R08
    tx_count == radio_spi_pkg::QUEUE_DEPTH)
    else $error("full write changed level");
  empty_keep_a: assert property (data_rd && !rx_push && rx_count == 2'h0 |=> rx_count == 2'h0) // R10
    else $error("empty read changed level");

  // Flags clear once their cause is gone; the empty flag sets once the last byte leaves
  tx_full_flag_a: assert property (tx_push && !tx_pop && tx_count == 2'h1 |=> !fifo_flags[0]) // R06
    else $error("slot flag set while full");
  tx_drain_flag_a: assert property (tx_pop && !tx_push && tx_count == 2'h1 |=> fifo_flags[1]) // R05
    else $error("empty flag missing");
  rx_drain_flag_a: assert property (rx_pop && !rx_push && rx_count == 2'h1 |=> !fifo_flags[2]) // R04
    else $error("available flag left set");
  rx_room_flag_a: assert property (rx_pop && !rx_push && rx_count == 2'h2 |=> !fifo_flags[3]) // R03
    else $error("full flag left set");

  // Launcher keeps one byte in flight
  csn_gate_a: assert property (radio_csn_out |-> !launch) // R13
    else $error("launch while deselected");
  rx_room_gate_a: assert property (rx_count == radio_spi_pkg::QUEUE_DEPTH |-> !launch) // R18
    else $error("launch with receive queue full");
  launch_byte_a: assert property (launch |=> tx_hold == $past(tx_mem[tx_rd_ptr]) && req != $past(req)) // R18
    else $error("launch lost the queued byte");
  busy_hold_a: assert property (launch_state == radio_spi_pkg::LAUNCH_BUSY && !ack_event |=> // R18
    launch_state == radio_spi_pkg::LAUNCH_BUSY)
    else $error("launcher freed early");
  ack_free_a: assert property (launch_state == radio_spi_pkg::LAUNCH_BUSY && ack_event |=> // R18
    launch_state == radio_spi_pkg::LAUNCH_IDLE)
    else $error("launcher stuck");
  stray_ack_a: assert property (ack_event |-> launch_state == radio_spi_pkg::LAUNCH_BUSY) // R18
    else $error("completion with nothing in flight");

  fill_tx_c: cover property (tx_count == 2'h2);
  fill_rx_c: cover property (rx_count == 2'h2);
  round_trip_c: cover property (launch ##[1:400] rx_push);
  irq_raise_c: cover property (!irq_out ##1 irq_out);
  tx_drop_c: cover property (data_wr && tx_count == radio_spi_pkg::QUEUE_DEPTH);

endmodule : radio_spi_master
`default_nettype wire

// ---- rtl/radio_spi_pkg.sv ----
// Constants and types for the radio SPI master register port.
// Assumes one system clock domain plus one link clock domain.
package radio_spi_pkg;

  // Register addresses
  localparam logic [7:0] RESERVED_CFG_ADDR = 8'hE4;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'hE5;
  localparam logic [7:0] FIFO_FLAGS_ADDR = 8'hE6;
  localparam logic [7:0] FIFO_DATA_ADDR = 8'hE7;
  localparam logic [7:0] CONTROL_ADDR = 8'hE8;

  // Values after reset
  localparam logic [6:0] RESERVED_CFG_RESET = 7'h01;
  localparam logic [3:0] IRQ_MASK_RESET = 4'hF;
  localparam logic [3:0] FIFO_FLAGS_RESET = 4'h3;
  localparam logic [7:0] FIFO_DATA_RESET = 8'h00;
  localparam logic [2:0] CONTROL_RESET = 3'h2;

  // Flag and mask bit positions
  localparam int FLAG_RX_FULL = 3;
  localparam int FLAG_RX_AVAIL = 2;
  localparam int FLAG_TX_EMPTY = 1;
  localparam int FLAG_TX_SLOT = 0;

  // Control bit positions
  localparam int CTRL_CLOCK_EN = 2;
  localparam int CTRL_SELECT_N = 1;
  localparam int CTRL_CHIP_EN = 0;

  // Queue shape and serial timing
  localparam logic [1:0] QUEUE_DEPTH = 2'd2;
  localparam logic [2:0] LAST_BIT_INDEX = 3'd7;
  localparam logic [1:0] HALF_BIT_LAST = 2'd3;

  typedef enum logic [1:0] {LINK_IDLE, LINK_LOW, LINK_HIGH} link_state_e;
  typedef enum logic {LAUNCH_IDLE, LAUNCH_BUSY} launch_state_e;

endpackage : radio_spi_pkg

// ---- rtl/link_handshake_if.sv ----
// Toggle handshake carrying one byte each way between system and link domains.
// Data is held stable by its sender while the matching toggle is in flight.
`timescale 1ns/1ps
`default_nettype none
interface link_handshake_if;
  logic req_toggle;
  logic [7:0] tx_byte;
  logic ack_toggle;
  logic [7:0] rx_byte;

  modport system_side (output req_toggle, output tx_byte, input ack_toggle, input rx_byte);
  modport link_side (input req_toggle, input tx_byte, output ack_toggle, output rx_byte);
endinterface : link_handshake_if
`default_nettype wire

// ---- rtl/spi_link_shifter.sv ----
// Link-domain byte shifter: SPI mode 0, MSB first, one byte per request toggle.
// Assumes the slave drives MISO after each falling SCK and holds it through the high phase.
`timescale 1ns/1ps
`default_nettype none
module spi_link_shifter (
  input wire logic link_clock_in,
  input wire logic rst_in,
  input wire logic miso_in,
  output logic sck_out,
  output logic mosi_out,
  link_handshake_if.link_side hs
);
  logic [1:0] rst_sync;
  logic link_rst;
  logic req_s1, req_s2, req_s3, req_seen;
  logic miso_s1, miso_s2, miso_s3, miso_level;
  radio_spi_pkg::link_state_e state;
  logic [2:0] bit_index;
  logic [1:0] half_count;
  logic [7:0] shift_out;
  logic [7:0] shift_in;
  logic ack;
  logic [7:0] rx_byte;

  // Reset brought into the link domain
  always_ff @(posedge link_clock_in) begin
    rst_sync <= {rst_sync[0], rst_in};
  end
  assign link_rst = rst_sync[1];

  always_ff @(posedge link_clock_in) begin
    if (link_rst) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
      miso_s3 <= 1'b0;
      miso_level <= 1'b0;
    end else begin
      req_s1 <= hs.req_toggle;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      miso_s1 <= miso_in;
      miso_s2 <= miso_s1;
      miso_s3 <= miso_s2;
      if (miso_s2 == miso_s3) begin
        miso_level <= miso_s3;
      end
    end
  end

  always_ff @(posedge link_clock_in) begin
    if (link_rst) begin
      state <= radio_spi_pkg::LINK_IDLE;
      req_seen <= 1'b0;
      bit_index <= 3'h0;
      half_count <= 2'h0;
      shift_out <= 8'h00;
      shift_in <= 8'h00;
      sck_out <= 1'b0;
      ack <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      case (state)
        radio_spi_pkg::LINK_IDLE: begin
          if (req_s2 == req_s3 && req_s3 != req_seen) begin
            req_seen <= req_s3;
            shift_out <= hs.tx_byte; // R17
            bit_index <= radio_spi_pkg::LAST_BIT_INDEX;
            half_count <= 2'h0;
            state <= radio_spi_pkg::LINK_LOW;
          end
        end
        radio_spi_pkg::LINK_LOW: begin
          half_count <= half_count + 2'd1;
          if (half_count == radio_spi_pkg::HALF_BIT_LAST) begin
            sck_out <= 1'b1;
            state <= radio_spi_pkg::LINK_HIGH;
          end
        end
        radio_spi_pkg::LINK_HIGH: begin
          half_count <= half_count + 2'd1;
          if (half_count == radio_spi_pkg::HALF_BIT_LAST) begin
            sck_out <= 1'b0;
            shift_in <= {shift_in[6:0], miso_level}; // R18
            shift_out <= {shift_out[6:0], 1'b0};
            if (bit_index == 3'h0) begin
              rx_byte <= {shift_in[6:0], miso_level}; // R16
              ack <= ~ack;
              state <= radio_spi_pkg::LINK_IDLE;
            end else begin
              bit_index <= bit_index - 3'd1;
              state <= radio_spi_pkg::LINK_LOW;
            end
          end
        end
        default: state <= radio_spi_pkg::LINK_IDLE;
      endcase
    end
  end

  assign mosi_out = shift_out[7];
  assign hs.ack_toggle = ack;
  assign hs.rx_byte = rx_byte;

  idle_clock_low_a: assert property (@(posedge link_clock_in) disable iff (link_rst) // R18
    state == radio_spi_pkg::LINK_IDLE |-> !sck_out)
    else $error("SCK high while link idle");

endmodule : spi_link_shifter
`default_nettype wire

// ---- bench/radio_slave_model.sv ----
// Behavioural model of the radio transceiver's SPI slave, mode 0.
// Assumes SCK idles low and moves only while the select line is low.
`timescale 1ns/1ps
`default_nettype none
module radio_slave_model #(
  parameter logic [7:0] STATUS_BYTE = 8'h0E,
  parameter logic [7:0] RESP_BASE = 8'h30,
  parameter int MISO_DELAY_NS = 1
) (
  input wire logic sck_in,
  input wire logic mosi_in,
  input wire logic csn_in,
  output logic miso_out
);
  logic [7:0] out_sr = 8'h00;
  logic [7:0] in_sr = 8'h00;
  logic [7:0] rx_log [0:7];
  int bit_n = 0;
  int byte_n = 0;

  initial miso_out = 1'b0;

  // New command: status goes out first
  always @(negedge csn_in) begin
    bit_n = 0;
    byte_n = 0;
    out_sr = STATUS_BYTE;
    miso_out = STATUS_BYTE[7];
  end

  // Released line shows the inverse of its last value
  always @(posedge csn_in) begin
    miso_out = ~miso_out;
  end

  always @(posedge sck_in) begin
    if (!csn_in) begin
      in_sr = {in_sr[6:0], mosi_in};
      bit_n = bit_n + 1;
      if (bit_n == 8) begin
        rx_log[byte_n[2:0]] = in_sr;
        bit_n = 0;
        byte_n = byte_n + 1;
        out_sr = RESP_BASE + byte_n[7:0];
      end
    end
  end

  // Slow answer: MISO moves a little after the falling edge
  always @(negedge sck_in) begin
    if (!csn_in) begin
      #(MISO_DELAY_NS);
      if (bit_n != 0) begin
        out_sr = {out_sr[6:0], 1'b0};
      end
      miso_out = out_sr[7];
    end
  end
endmodule : radio_slave_model
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench for the radio SPI master register port.
// Assumes 200 MHz system clock and a free 15 ns link clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock_in = 1'b0;
  logic link_clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] sfr_addr_in = 8'h00;
  logic sfr_wr_in = 1'b0;
  logic sfr_rd_in = 1'b0;
  logic [7:0] sfr_wdata_in = 8'h00;
  logic [7:0] sfr_rdata_out;
  logic irq_out;
  logic radio_sck, radio_mosi, radio_miso, radio_csn, radio_ce, radio_clken;
  int fail_count = 0;
  int compares = 0;
  localparam logic [7:0] STATUS_BYTE = 8'h0E;
  localparam logic [7:0] RESP_BASE = 8'h30;

  always #2.5 clock_in = ~clock_in;
  initial begin
    #3.3;
    forever #7.5 link_clock_in = ~link_clock_in;
  end

  radio_spi_master DUT (.clock_in(clock_in), .rst_in(rst_in), .link_clock_in(link_clock_in),
    .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_wdata_in(sfr_wdata_in),
    .sfr_rdata_out(sfr_rdata_out), .irq_out(irq_out), .radio_sck_out(radio_sck),
    .radio_mosi_out(radio_mosi), .radio_miso_in(radio_miso), .radio_csn_out(radio_csn),
    .radio_ce_out(radio_ce), .radio_clock_enable_line_out(radio_clken));

  radio_slave_model #(.STATUS_BYTE(STATUS_BYTE), .RESP_BASE(RESP_BASE)) radio (.sck_in(radio_sck),
    .mosi_in(radio_mosi), .csn_in(radio_csn), .miso_out(radio_miso));

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    sfr_addr_in <= a;
    sfr_wdata_in <= d;
    sfr_wr_in <= 1'b1;
    @(posedge clock_in);
    sfr_wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_in);
    sfr_addr_in <= a;
    sfr_rd_in <= 1'b1;
    @(posedge clock_in);
    sfr_rd_in <= 1'b0;
    #1;
    d = sfr_rdata_out;
  endtask : rd

  task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    check($sformatf("reg %h", a), v, exp);
  endtask : expect_reg

  task automatic settle;
    repeat (2) @(posedge clock_in);
    #1;
  endtask : settle

  // Poll flags until all bits of m are set, bounded
  task automatic wait_flags(input logic [7:0] m);
    logic [7:0] v;
    for (int i = 0; i < 600; i++) begin
      rd(radio_spi_pkg::FIFO_FLAGS_ADDR, v);
      if ((v & m) === m) begin
        return;
      end
    end
    check("flags wait", v & m, m);
    summarize();
  endtask : wait_flags

  task automatic test_reset_values;
    expect_reg(radio_spi_pkg::RESERVED_CFG_ADDR, 8'h01);
    expect_reg(radio_spi_pkg::IRQ_MASK_ADDR, 8'h0F);
    expect_reg(radio_spi_pkg::FIFO_FLAGS_ADDR, 8'h03);
    expect_reg(radio_spi_pkg::FIFO_DATA_ADDR, 8'h00);
    check("csn", {7'h00, radio_csn}, 8'h01);
    check("ce", {7'h00, radio_ce}, 8'h00);
    check("clken", {7'h00, radio_clken}, 8'h00);
    check("irq", {7'h00, irq_out}, 8'h00);
    $display("test_reset_values done");
  endtask : test_reset_values

  task automatic test_control_lines;
    logic [7:0] vals [4] = '{8'hFF, 8'h04, 8'h01, 8'h02};
    foreach (vals[i]) begin
      wr(radio_spi_pkg::CONTROL_ADDR, vals[i]);
      settle();
      expect_reg(radio_spi_pkg::CONTROL_ADDR, vals[i] & 8'h07);
      check("clken", {7'h00, radio_clken}, {7'h00, vals[i][2]});
      check("csn", {7'h00, radio_csn}, {7'h00, vals[i][1]});
      check("ce", {7'h00, radio_ce}, {7'h00, vals[i][0]});
    end
    $display("test_control_lines done");
  endtask : test_control_lines

  task automatic test_read_only;
    wr(radio_spi_pkg::FIFO_FLAGS_ADDR, 8'h00);
    expect_reg(radio_spi_pkg::FIFO_FLAGS_ADDR, 8'h03);
    expect_reg(8'hE9, 8'h00);
    $display("test_read_only done");
  endtask : test_read_only

  task automatic test_irq_mask;
    logic [7:0] m;
    for (int i = 0; i < 4; i++) begin
      m = ~(8'h01 << i) & 8'h0F;
      wr(radio_spi_pkg::IRQ_MASK_ADDR, m);
      settle();
      expect_reg(radio_spi_pkg::IRQ_MASK_ADDR, m);
      check("irq", {7'h00, irq_out}, {7'h00, (i < 2)});
    end
    wr(radio_spi_pkg::IRQ_MASK_ADDR, 8'h0F);
    settle();
    check("irq", {7'h00, irq_out}, 8'h00);
    $display("test_irq_mask done");
  endtask : test_irq_mask

  // Slave deselected, so bytes wait in the transmit queue
  task automatic test_tx_queue;
    wr(radio_spi_pkg::IRQ_MASK_ADDR, 8'h0D);
    wr(radio_spi_pkg::FIFO_DATA_ADDR, 8'hA1);
    expect_reg(radio_spi_pkg::FIFO_FLAGS_ADDR, 8'h01);
    settle();
    check("irq", {7'h00, irq_out}, 8'h00);
    wr(radio_spi_pkg::FIFO_DATA_ADDR, 8'h3C);
    expect_reg(radio_spi_pkg::FIFO_FLAGS_ADDR, 8'h00);
    wr(radio_spi_pkg::FIFO_DATA_ADDR, 8'h99);
    expect_reg(radio_spi_pkg::FIFO_FLAGS_ADDR, 8'h00);
    $display("test_tx_queue done");
  endtask : test_tx_queue

  task automatic test_transfer;
    wr(radio_spi_pkg::IRQ_MASK_ADDR, 8'h0B);
    wr(radio_spi_pkg::CONTROL_ADDR, 8'h00);
    wait_flags(8'h08);
    expect_reg(radio_spi_pkg::FIFO_FLAGS_ADDR, 8'h0F);
    check("irq", {7'h00, irq_out}, 8'h01);
    wr(radio_spi_pkg::IRQ_MASK_ADDR, 8'h07);
    settle();
    check("irq full", {7'h00, irq_out}, 8'h01);
    check("sent0", radio.rx_log[0], 8'hA1);
    check("sent1", radio.rx_log[1], 8'h3C);
    wr(radio_spi_pkg::FIFO_DATA_ADDR, 8'h77);
    repeat (300) @(posedge clock_in);
    expect_reg(radio_spi_pkg::FIFO_FLAGS_ADDR, 8'h0D);
    expect_reg(radio_spi_pkg::FIFO_DATA_ADDR, STATUS_BYTE);
    wait_flags(8'h0A);
    check("sent2", radio.rx_log[2], 8'h77);
    expect_reg(radio_spi_pkg::FIFO_DATA_ADDR, RESP_BASE + 8'h01);
    expect_reg(radio_spi_pkg::FIFO_FLAGS_ADDR, 8'h07);
    expect_reg(radio_spi_pkg::FIFO_DATA_ADDR, RESP_BASE + 8'h02);
    expect_reg(radio_spi_pkg::FIFO_FLAGS_ADDR, 8'h03);
    expect_reg(radio_spi_pkg::FIFO_DATA_ADDR, 8'h00);
    settle();
    check("irq", {7'h00, irq_out}, 8'h00);
    wr(radio_spi_pkg::CONTROL_ADDR, 8'h02);
    $display("test_transfer done");
  endtask : test_transfer

  initial begin
    repeat (8) @(posedge clock_in);
    rst_in <= 1'b0;
    repeat (10) @(posedge clock_in);
    test_reset_values();
    test_control_lines();
    test_read_only();
    test_irq_mask();
    test_tx_queue();
    test_transfer();
    summarize();
  end
endmodule : testbench
`default_nettype wire
